// ===== sbs_pkg.sv
package sbs_pkg;

	localparam int ADDR_W      = 20;
	localparam int LANES       = 4;
	localparam int LANE_W      = 9;
	localparam int WORD_W      = LANES * LANE_W;
	localparam int BURST_W     = 2;
	localparam int MEM_AW      = 4;
	localparam int MEM_DEPTH   = 1 << MEM_AW;
	localparam int SYNC_STAGES = 3;
	localparam int BUF_DEPTH   = 2;
	localparam int BUF_CNT_W   = 2;

	localparam logic [BURST_W-1:0]   BURST_ZERO = 2'h0;
	localparam logic [BURST_W-1:0]   BURST_ONE  = 2'h1;
	localparam logic [BUF_CNT_W-1:0] CNT_ZERO   = 2'h0;
	localparam logic [BUF_CNT_W-1:0] CNT_ONE    = 2'h1;
	localparam logic [BUF_CNT_W-1:0] CNT_FULL   = 2'h2;

	// synchronous control pins, sampled on every rising core_clk edge
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              procStrobeN;
		logic              ctrlStrobeN;
		logic              chipSelectPrimaryN;
		logic              chipSelectHigh;
		logic              chipSelectThirdN;
		logic              burstStepN;
		logic              globalWriteN;
		logic              byteWriteGateN;
		logic [LANES-1:0]  byteLaneWriteSelectN;
	} sbs_ctrl_t;

	// read word with its output-enable mask travelling through the buffer
	typedef struct packed {
		logic              mask;
		logic [WORD_W-1:0] word;
	} sbs_rd_t;

endpackage

// ===== sbs_skid_buffer.sv
`timescale 1ns/1ps
module sbs_skid_buffer
	import sbs_pkg::*;
#(
	parameter int W = WORD_W + 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         inValid,
	input  wire logic [W-1:0] inData,
	output logic              inReady,
	output logic              outValid,
	output logic [W-1:0]      outData,
	input  wire logic         outReady
);

	typedef struct packed {
		logic [BUF_DEPTH-1:0][W-1:0] data;
		logic [BUF_CNT_W-1:0]        count;
	} sbs_buf_state_t;

	sbs_buf_state_t s;
	sbs_buf_state_t next_s;
	logic           push;
	logic           pop;

	assign inReady  = s.count != CNT_FULL;
	assign outValid = s.count != CNT_ZERO;
	assign outData  = s.data[0];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	always_comb begin
		next_s = s;
		if (pop) begin
			next_s.data[0] = s.data[1];
			next_s.count   = s.count - CNT_ONE;
		end
		if (push) begin
			next_s.data[next_s.count[0]] = inData;
			next_s.count                 = next_s.count + CNT_ONE;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule

// ===== sbs_burst_sram_port.sv
`timescale 1ns/1ps
module sbs_burst_sram_port
	import sbs_pkg::*;
#(
	parameter bit HAS_THIRD_SELECT = 1'b1
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire sbs_ctrl_t         ctrl,
	input  wire logic [WORD_W-1:0] dataIn,
	output logic [WORD_W-1:0]      dataOut,
	output logic                   dataOe,
	output logic                   readValid,
	input  wire logic              outputEnableN,
	input  wire logic              sleepRequest,
	input  wire logic              burstOrderStrap,
	output logic                   sleeping,
	output logic                   bufferFree
);

	typedef struct packed {
		logic [MEM_DEPTH-1:0][WORD_W-1:0] mem;
		logic [ADDR_W-1:0]                baseAddr;
		logic [BURST_W-1:0]               startLow;
		logic [BURST_W-1:0]               stepCount;
		logic                             active;
		logic                             wasDeselected;
		logic                             burstInterleaved;
		logic                             strapTaken;
		logic [SYNC_STAGES-1:0]           oeSync;
		logic                             oeFilt;
		logic [SYNC_STAGES-1:0]           sleepSync;
		logic                             sleepFilt;
		logic [WORD_W-1:0]                dataOut;
		logic                             dataOe;
		logic                             readValid;
		logic                             sleeping;
		logic                             bufferFree;
	} sbs_state_t;

	sbs_state_t       s;
	sbs_state_t       next_s;
	logic             selected;
	logic             procLoad;
	logic             ctrlLoad;
	logic             load;
	logic             access;
	logic [LANES-1:0] laneWr;
	logic             anyWrite;
	logic             readPush;
	logic [MEM_AW-1:0] idx;
	logic             bufInReady;
	logic             bufOutValid;
	logic             bufOutReady;
	sbs_rd_t          bufIn;
	sbs_rd_t          bufOut;

	// low address bits of the current beat for either burst order
	function automatic logic [BURST_W-1:0] burst_low(
		input logic [BURST_W-1:0] start,
		input logic [BURST_W-1:0] step,
		input logic               interleaved
	);
		logic [BURST_W-1:0] res;
		res = interleaved ? (start ^ step) : BURST_W'(start + step);
		return res;
	endfunction

	function automatic logic [MEM_AW-1:0] word_index(
		input logic [ADDR_W-1:0]  base,
		input logic [BURST_W-1:0] low
	);
		logic [MEM_AW-1:0] res;
		res = {base[MEM_AW-1:BURST_W], low};
		return res;
	endfunction

	// chip selects only matter on a load edge
	assign selected = !ctrl.chipSelectPrimaryN && ctrl.chipSelectHigh
		&& (!ctrl.chipSelectThirdN || !HAS_THIRD_SELECT);
	assign procLoad = !ctrl.procStrobeN && !ctrl.chipSelectPrimaryN;
	assign ctrlLoad = !ctrl.ctrlStrobeN && !procLoad;
	assign load     = procLoad || ctrlLoad;
	// an edge is an access on a selected load or a beat of a running burst;
	// a full buffer or sleep refuses it so that no read word is lost
	assign access   = !s.sleepFilt && bufInReady && s.strapTaken
		&& (load ? selected : s.active);

	// lane write enables; a processor-strobe load edge is always a read
	genvar lane;
	generate
		for (lane = 0; lane < LANES; lane++) begin : g_lane
			assign laneWr[lane] = access && !procLoad && (!ctrl.globalWriteN
				|| (!ctrl.byteWriteGateN && !ctrl.byteLaneWriteSelectN[lane]));
		end
	endgenerate

	assign anyWrite    = |laneWr;
	assign readPush    = access && !anyWrite;
	// the mask rides with its word so a stalled first read stays undriven
	assign bufIn       = '{mask: s.wasDeselected, word: s.mem[idx]};
	assign bufOutReady = !s.oeFilt && !s.sleepFilt;

	always_comb begin
		next_s   = s;

		// asynchronous pins: a change counts once stages two and three agree
		next_s.oeSync    = {s.oeSync[SYNC_STAGES-2:0], outputEnableN};
		next_s.sleepSync = {s.sleepSync[SYNC_STAGES-2:0], sleepRequest};
		if (s.oeSync[SYNC_STAGES-1] == s.oeSync[SYNC_STAGES-2]) begin
			next_s.oeFilt = s.oeSync[SYNC_STAGES-1];
		end
		if (s.sleepSync[SYNC_STAGES-1] == s.sleepSync[SYNC_STAGES-2]) begin
			next_s.sleepFilt = s.sleepSync[SYNC_STAGES-1];
		end

		// strap caught once after reset release
		if (!s.strapTaken) begin
			next_s.burstInterleaved = burstOrderStrap;
			next_s.strapTaken       = 1'b1;
		end

		if (s.sleepFilt) begin
			next_s.active        = 1'b0;
			next_s.wasDeselected = 1'b1;
		end else if (bufInReady && s.strapTaken) begin
			if (load) begin
				next_s.active = selected;
				if (selected) begin
					next_s.baseAddr  = ctrl.addr;
					next_s.startLow  = ctrl.addr[BURST_W-1:0];
					next_s.stepCount = BURST_ZERO;
				end else begin
					next_s.wasDeselected = 1'b1;
				end
			end else if (s.active) begin
				if (!ctrl.burstStepN) begin
					next_s.stepCount = s.stepCount + BURST_ONE;
				end
			end
		end

		// the index follows the beat that this edge selects
		idx = word_index(next_s.baseAddr,
			burst_low(next_s.startLow, next_s.stepCount, s.burstInterleaved));

		for (int i = 0; i < LANES; i++) begin
			if (laneWr[i]) begin
				next_s.mem[idx][i*LANE_W +: LANE_W] = dataIn[i*LANE_W +: LANE_W];
			end
		end
		if (readPush) begin
			next_s.wasDeselected = 1'b0;
		end

		// output register: one word per cycle while output enable is low and sleep is off
		if (bufOutValid && bufOutReady) begin
			next_s.dataOut   = bufOut.word;
			next_s.dataOe    = !bufOut.mask;
			next_s.readValid = 1'b1;
		end else begin
			next_s.dataOe    = 1'b0;
			next_s.readValid = 1'b0;
		end
		// pins turn off as soon as the filtered enable goes high
		if (next_s.oeFilt) begin
			next_s.dataOe = 1'b0;
		end

		next_s.sleeping   = s.sleepFilt;
		next_s.bufferFree = bufInReady;
	end

	sbs_skid_buffer #(
		.W($bits(sbs_rd_t))
	) u_buf (
		.core_clk (core_clk),
		.rst      (rst),
		.inValid  (readPush),
		.inData   (bufIn),
		.inReady  (bufInReady),
		.outValid (bufOutValid),
		.outData  (bufOut),
		.outReady (bufOutReady)
	);

	// reset leaves the filtered output enable high, so pins start undriven
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s               <= '0;
			s.wasDeselected <= 1'b1;
			s.oeSync        <= '1;
			s.oeFilt        <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign dataOut    = s.dataOut;
	assign dataOe     = s.dataOe;
	assign readValid  = s.readValid;
	assign sleeping   = s.sleeping;
	assign bufferFree = s.bufferFree;

endmodule

// ===== sbs_host_model.sv
`timescale 1ns/1ps
module sbs_host_model
	import sbs_pkg::*;
(
	input  wire logic         core_clk,
	output sbs_ctrl_t         ctrl,
	output logic [WORD_W-1:0] dataIn
);
	initial begin
		ctrl = '1;
		dataIn = '0;
	end
	// pins move only after the falling edge
	task automatic put(input sbs_ctrl_t c, input logic [WORD_W-1:0] d);
		@(negedge core_clk);
		ctrl <= c;
		dataIn <= d;
	endtask
endmodule

// ===== sbs_port_assertions.sv
`timescale 1ns/1ps
module sbs_port_assertions
	import sbs_pkg::*;
#(
	parameter bit HAS_THIRD_SELECT = 1'b1
) (
	input wire logic      core_clk,
	input wire logic      rst,
	input wire sbs_ctrl_t ctrl,
	input wire logic      dataOe,
	input wire logic      readValid,
	input wire logic      outputEnableN,
	input wire logic      sleepRequest,
	input wire logic      sleeping,
	input wire logic      bufferFree
);
	logic [3:0] calm;
	logic       ld;
	logic       sel;
	logic       rd;
	logic       ok;
	logic       nwr;
	assign ld = !ctrl.procStrobeN && !ctrl.chipSelectPrimaryN || !ctrl.ctrlStrobeN;
	assign sel = !ctrl.chipSelectPrimaryN && ctrl.chipSelectHigh
		&& (!ctrl.chipSelectThirdN || !HAS_THIRD_SELECT);
	assign nwr = ctrl.globalWriteN && (ctrl.byteWriteGateN || &ctrl.byteLaneWriteSelectN);
	assign rd = ld && sel && (!ctrl.procStrobeN || nwr);
	// outputs long enabled and no sleep lately
	assign ok = calm > 4'h9;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			calm <= 4'h0;
		else
			calm <= outputEnableN || sleepRequest || sleeping ? 4'h0 : calm + 4'(calm != 4'hF);
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_oe; dataOe |-> readValid; endproperty
	property p_lat; rd && ok |-> ##2 readValid; endproperty
	property p_mask; (ld && !sel && ok) ##1 rd |-> ##2 !dataOe; endproperty
	property p_desel; ld && !sel && ok |-> ##2 !readValid; endproperty
	// a read beat with primary select high and no controller strobe keeps the burst going
	property p_ps; (rd && ok) ##1 (ctrl.chipSelectPrimaryN && ctrl.ctrlStrobeN && nwr && ok)
		|-> ##2 readValid;
	endproperty
	property p_in; sleepRequest [*6] |=> sleeping; endproperty
	property p_out; !sleepRequest [*6] |=> !sleeping; endproperty
	property p_free; ok |-> bufferFree; endproperty
	a_oe: assert property (p_oe) else $error("driven without word");
	a_lat: assert property (p_lat) else $error("read late");
	a_mask: assert property (p_mask) else $error("first read driven");
	a_desel: assert property (p_desel) else $error("word when deselected");
	a_ps: assert property (p_ps) else $error("burst beat lost");
	a_in: assert property (p_in) else $error("no sleep");
	a_out: assert property (p_out) else $error("stuck asleep");
	a_free: assert property (p_free) else $error("buffer stuck");
	c_mask: cover property (readValid && !dataOe);
	c_drv: cover property (readValid && dataOe);
	c_slp: cover property (sleeping);
	c_full: cover property (!bufferFree);
endmodule
bind sbs_burst_sram_port sbs_port_assertions #(.HAS_THIRD_SELECT(HAS_THIRD_SELECT)) chk_inst (
	.core_clk(core_clk), .rst(rst), .ctrl(ctrl), .dataOe(dataOe), .readValid(readValid),
	.outputEnableN(outputEnableN), .sleepRequest(sleepRequest), .sleeping(sleeping),
	.bufferFree(bufferFree));

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import sbs_pkg::*;
	logic              core_clk, rst, oeN, slp, strap, oe, rv, asleep, free;
	logic [WORD_W-1:0] din, dout, w;
	logic [WORD_W-1:0] mem [MEM_DEPTH];
	logic [WORD_W-1:0] expQ [$];
	logic              oeQ [$];
	logic [3:0]        st;
	logic [1:0]        k;
	sbs_ctrl_t         ctrl, c;
	int                miscompares, compares;
	int                seed = 15374;
	sbs_burst_sram_port sbs_burst_sram_port_inst (.core_clk(core_clk), .rst(rst), .ctrl(ctrl),
		.dataIn(din), .dataOut(dout), .dataOe(oe), .readValid(rv), .outputEnableN(oeN),
		.sleepRequest(slp), .burstOrderStrap(strap), .sleeping(asleep), .bufferFree(free));
	sbs_host_model sbs_host_model_inst (.core_clk(core_clk), .ctrl(ctrl), .dataIn(din));
	initial begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input string nm, input logic [WORD_W-1:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	function automatic sbs_ctrl_t pick(input logic [3:0] a);
		pick = '1;
		pick.addr = {16'($random(seed)), a};
		pick.ctrlStrobeN = 1'b0;
		pick.chipSelectPrimaryN = 1'b0;
		pick.chipSelectThirdN = 1'b0;
	endfunction
	// send c, and queue the word a read of a should return
	task automatic go(input bit r, input logic [3:0] a, input logic e);
		sbs_host_model_inst.put(c, w);
		if (r) begin
			expQ.push_back(mem[a]);
			oeQ.push_back(e);
		end
	endtask
	task automatic desel;
		w = ~w;
		c = '1;
		c.ctrlStrobeN = 1'b0;
		go(0, 0, 0);
	endtask
	always @(negedge core_clk) begin
		if (!rst && rv === 1'b1) begin
			chk("extra", expQ.size() > 0, 1);
			if (expQ.size() > 0) begin
				chk("dout", dout, expQ.pop_front());
				chk("oe", oe, oeQ.pop_front());
			end
		end
	end
	initial begin
		repeat (6000) @(posedge core_clk);
		miscompares++;
		close_out();
	end
	initial begin
		{rst, oeN, slp, strap, w} = '0;
		for (int s = 0; s < 2; s++) begin
			rst = 1;
			strap = s[0];
			repeat (5) @(negedge core_clk);
			rst = 0;
			for (int a = 0; a < 28; a++) begin
				w = {4'($random(seed)), 32'($random(seed))};
				c = pick(a < 16 ? a[3:0] : 4'($random(seed)));
				c.globalWriteN = a > 15;
				c.byteWriteGateN = 1'($random(seed));
				c.byteLaneWriteSelectN = {3'($random(seed)), c.byteWriteGateN};
				for (int i = 0; i < LANES; i++)
					if (a < 16 || !c.byteWriteGateN && !c.byteLaneWriteSelectN[i])
						mem[c.addr[3:0]][i*LANE_W +: LANE_W] = w[i*LANE_W +: LANE_W];
				go(a > 15 && c.byteWriteGateN, c.addr[3:0], 0);
				desel();
			end
			slp = 1;
			repeat (10) @(negedge core_clk);
			chk("asleep", asleep, 1);
			slp = 0;
			repeat (12) @(negedge core_clk);
			chk("awake", asleep, 0);
			repeat (10) begin
				st = 4'($random(seed));
				c = pick(st);
				c.procStrobeN = 1'($random(seed));
				go(1, st, 0);
				k = 0;
				repeat (4) begin
					c.ctrlStrobeN = 1;
					c.addr = 20'($random(seed));
					c.chipSelectPrimaryN = 1'($random(seed));
					// processor strobe only while primary select is high, where it is ignored
					c.procStrobeN = c.chipSelectPrimaryN ? 1'($random(seed)) : 1'h1;
					c.burstStepN = 1'($random(seed));
					k = k + 2'(!c.burstStepN);
					go(1, {st[3:2], strap ? st[1:0] ^ k : st[1:0] + k}, 1);
				end
				desel();
			end
			// stall: output enable high, two reads fill the buffer, a deselect waits
			oeN = 1;
			repeat (6) @(negedge core_clk);
			st = 4'($random(seed));
			c = pick(st);
			go(1, st, 0);
			st = 4'($random(seed));
			c = pick(st);
			go(1, st, 1);
			desel();
			@(negedge core_clk);
			chk("full", free, 0);
			oeN = 0;
			repeat (12) @(negedge core_clk);
			c = pick(0);
			{c.ctrlStrobeN, c.procStrobeN, c.chipSelectPrimaryN} = 3'h5;
			go(0, 0, 0);
			c = pick(0);
			c.chipSelectHigh = 0;
			go(0, 0, 0);
			c = pick(0);
			c.chipSelectThirdN = 1;
			go(0, 0, 0);
			desel();
			repeat (4) @(negedge core_clk);
			chk("left", expQ.size(), 0);
			chk("free", free, 1);
		end
		close_out();
	end
endmodule
